// >>> design/pfs_cfg.svh
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define PFS_CLK_HZ 40000000
`define PFS_SHORT_NS 6000
`define PFS_SHORT_CYC ((`PFS_SHORT_NS * (`PFS_CLK_HZ / 1000000)) / 1000)
`define PFS_OT_DELAY_US 2000
`define PFS_OT_DELAY_CYC (`PFS_OT_DELAY_US * (`PFS_CLK_HZ / 1000000))
`define PFS_RETRY_MS 130
`define PFS_RETRY_CYC (`PFS_RETRY_MS * (`PFS_CLK_HZ / 1000))
`define PFS_FILT_W 17
`define PFS_RETRY_W 23

// ---------------------------------------------------------------------------
// Thresholds, in percent of setpoint, degrees Celsius and millivolts
// ---------------------------------------------------------------------------
`define PFS_PCT_FULL 8'h64
`define PFS_UV_BASE_PCT 8'h4B
`define PFS_PG_LO_BASE_PCT 8'h5A
`define PFS_PCT_STEP 8'h05
`define PFS_PG_HI_PCT 8'h6E
`define PFS_OT_OFF_C 10'sh078
`define PFS_OT_ON_C 10'sh06E
`define PFS_WARN_C 10'sh078
`define PFS_WARN_HYST_C 10'sh003
`define PFS_TRACK_MV 16'h00FA

// ---------------------------------------------------------------------------
// Register map, reset values and indices
// ---------------------------------------------------------------------------
`define PFS_ADDR_W 8
`define PFS_OFF_CTRL 8'h00
`define PFS_OFF_THR 8'h04
`define PFS_OFF_VSET 8'h08
`define PFS_OFF_STAT 8'h0C
`define PFS_CTRL_W 5
`define PFS_THR_W 3
`define PFS_STAT_W 6
`define PFS_VSET_W 16
`define PFS_CTRL_RST 5'h01
`define PFS_THR_RST 3'h0
`define PFS_VSET_RST 16'h09C4
`define PFS_NPROT 3
`define PFS_P_UV 0
`define PFS_P_OT 1
`define PFS_P_TRK 2
`define PFS_NFILT 5
`define PFS_F_WARN 3
`define PFS_F_PG 4

`endif

// >>> design/pfs_pkg.sv
package pfs_pkg;

    // Protection state: running, tripped with retry, or locked until reset.
    typedef enum logic [1:0] {
        PFS_RUN = 2'b00,
        PFS_TRIP = 2'b01,
        PFS_LOCK = 2'b10
    } pfs_prot_st_t;

    // Samples from the measurement front end, on pclk.
    typedef struct packed {
        logic [15:0] vout_mv;
        logic [15:0] track_ref_mv;
        logic signed [9:0] temp_c;
        logic ramp_up;
    } pfs_meas_t;

    // Control register: bit 0 output enable, bit 1 tracking enable, bits 4:2 latch.
    typedef struct packed {
        logic [2:0] latch;
        logic track_en;
        logic out_en;
    } pfs_ctrl_t;

    // Threshold register: bits 1:0 undervoltage step, bit 2 power-good step.
    typedef struct packed {
        logic pg_sel;
        logic [1:0] uv_sel;
    } pfs_thr_t;

    // Status register: bits 2:0 faults, 3 warning, 4 power good, 5 turn-off.
    typedef struct packed {
        logic turn_off;
        logic pg;
        logic ot_warn;
        logic [2:0] fault;
    } pfs_stat_t;

endpackage : pfs_pkg

// >>> design/pfs_settle.sv
`timescale 1ns/1ps

// Output follows the input only after the input has differed from it for
// span consecutive cycles, so both edges are delayed by exactly span cycles.
module pfs_settle #(
    parameter int unsigned CW = 17
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_lvl,
    input wire logic [CW-1:0] span,
    output logic out_lvl
);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic out_nxt;

    // ------------------------------------------------------------------------
    // Settling counter
    // ------------------------------------------------------------------------
    // A glitch shorter than span restarts the count, which filters noise.
    always_comb begin
        cnt_nxt = '0;
        out_nxt = out_lvl;
        if (in_lvl != out_lvl) begin
            if (cnt_r >= span - CW'(1)) begin
                out_nxt = in_lvl;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            out_lvl <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_lvl <= out_nxt;
        end
    end

endmodule : pfs_settle

// >>> design/pfs_supervisor.sv
// Contract
// - Flag undervoltage below 75 to 90 percent of setpoint, 5 percent steps.
// - Undervoltage turn-off follows the crossing by 6 microseconds.
// - Shut down at 120 C rising; restart only after cooling to 110 C.
// - Overtemperature turn-off follows reaching the threshold by 2 milliseconds.
// - When enabled, check tracking error above 250 mV only while ramping up.
// - Always monitor 120 C warning with 3 C hysteresis, shown in status.
// - The warning asserts 6 microseconds after its threshold is exceeded.
// - Power good is high inside the window and low outside it.
// - Window is 90 or 95 percent up to a fixed 110 percent of setpoint.
// - Power good changes 6 microseconds after a window threshold crossing.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pfs_cfg.svh"

module pfs_supervisor #(
    parameter int unsigned OT_DELAY_CYC = `PFS_OT_DELAY_CYC,
    parameter int unsigned RETRY_CYC = `PFS_RETRY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pfs_pkg::pfs_meas_t meas,
    output logic power_good_out,
    output logic turn_off,
    output logic pwm_enable
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic pfs_below(input logic [15:0] v, input logic [15:0] s,
                                       input logic [7:0] pct);
        pfs_below = (24'(v) * 24'(`PFS_PCT_FULL)) < (24'(s) * 24'(pct));
    endfunction : pfs_below

    function automatic logic pfs_above(input logic [15:0] v, input logic [15:0] s,
                                       input logic [7:0] pct);
        pfs_above = (24'(v) * 24'(`PFS_PCT_FULL)) > (24'(s) * 24'(pct));
    endfunction : pfs_above

    function automatic logic pfs_mapped(input logic [7:0] a);
        pfs_mapped = (a == `PFS_OFF_CTRL) || (a == `PFS_OFF_THR) ||
                     (a == `PFS_OFF_VSET) || (a == `PFS_OFF_STAT);
    endfunction : pfs_mapped

    pfs_pkg::pfs_ctrl_t ctrl_r, ctrl_nxt;
    pfs_pkg::pfs_thr_t thr_r, thr_nxt;
    logic [15:0] vset_r, vset_nxt;
    logic [31:0] prdata_nxt;
    pfs_pkg::pfs_stat_t stat;
    pfs_pkg::pfs_prot_st_t st_r [`PFS_NPROT];
    pfs_pkg::pfs_prot_st_t st_nxt [`PFS_NPROT];
    logic [`PFS_RETRY_W-1:0] rcnt_r [`PFS_NPROT];
    logic [`PFS_RETRY_W-1:0] rcnt_nxt [`PFS_NPROT];
    logic [`PFS_NFILT-1:0] raw;
    logic [`PFS_NFILT-1:0] settled;
    logic [`PFS_FILT_W-1:0] span [`PFS_NFILT];
    logic [`PFS_NPROT-1:0] release_ok;
    logic warn_lvl_r, warn_lvl_nxt;
    logic turn_off_nxt, pwm_en_nxt;
    logic [7:0] uv_pct, pg_pct;
    logic [15:0] trk_err;
    logic apb_wr;

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // Zero wait states; read data is captured in the setup cycle so that it
    // comes from a flip-flop when the access phase completes.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !pfs_mapped(paddr);
    assign apb_wr = psel && penable && pwrite;

    always_comb begin
        ctrl_nxt = ctrl_r;
        thr_nxt = thr_r;
        vset_nxt = vset_r;
        prdata_nxt = prdata;
        if (apb_wr) begin
            case (paddr)
                `PFS_OFF_CTRL: ctrl_nxt = pfs_pkg::pfs_ctrl_t'(pwdata[`PFS_CTRL_W-1:0]);
                `PFS_OFF_THR: thr_nxt = pfs_pkg::pfs_thr_t'(pwdata[`PFS_THR_W-1:0]);
                `PFS_OFF_VSET: vset_nxt = pwdata[`PFS_VSET_W-1:0];
                default: ;
            endcase
        end
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `PFS_OFF_CTRL: prdata_nxt = 32'(ctrl_r);
                `PFS_OFF_THR: prdata_nxt = 32'(thr_r);
                `PFS_OFF_VSET: prdata_nxt = 32'(vset_r);
                `PFS_OFF_STAT: prdata_nxt = 32'(stat);
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Tracking protection comes out of reset disabled and non-latching.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= pfs_pkg::pfs_ctrl_t'(`PFS_CTRL_RST);
            thr_r <= pfs_pkg::pfs_thr_t'(`PFS_THR_RST);
            vset_r <= `PFS_VSET_RST;
            prdata <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            thr_r <= thr_nxt;
            vset_r <= vset_nxt;
            prdata <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Threshold comparators
    // ------------------------------------------------------------------------
    // Undervoltage is only meaningful once the output is up, so it is masked
    // while the stage is off or still ramping.
    assign uv_pct = `PFS_UV_BASE_PCT + 8'(thr_r.uv_sel) * `PFS_PCT_STEP;
    assign pg_pct = `PFS_PG_LO_BASE_PCT + 8'(thr_r.pg_sel) * `PFS_PCT_STEP;
    assign trk_err = (meas.vout_mv > meas.track_ref_mv) ?
                     (meas.vout_mv - meas.track_ref_mv) : (meas.track_ref_mv - meas.vout_mv);

    always_comb begin
        raw[`PFS_P_UV] = pwm_enable && !meas.ramp_up &&
                         pfs_below(meas.vout_mv, vset_r, uv_pct);
        raw[`PFS_P_OT] = meas.temp_c >= `PFS_OT_OFF_C;
        raw[`PFS_P_TRK] = ctrl_r.track_en && meas.ramp_up &&
                          (trk_err > `PFS_TRACK_MV);
        raw[`PFS_F_WARN] = warn_lvl_r;
        raw[`PFS_F_PG] = !pfs_below(meas.vout_mv, vset_r, pg_pct) &&
                         !pfs_above(meas.vout_mv, vset_r, `PFS_PG_HI_PCT);
    end

    // Warning level with hysteresis: set at 120 C, cleared at 117 C and below.
    always_comb begin
        if (warn_lvl_r) begin
            warn_lvl_nxt = meas.temp_c > (`PFS_WARN_C - `PFS_WARN_HYST_C);
        end else begin
            warn_lvl_nxt = meas.temp_c >= `PFS_WARN_C;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_lvl_r <= 1'b0;
        end else begin
            warn_lvl_r <= warn_lvl_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Delay filters
    // ------------------------------------------------------------------------
    // Every comparator is held off by its nominal delay; the overtemperature
    // delay is long so that a brief hot spot does not stop the converter.
    always_comb begin
        for (int i = 0; i < `PFS_NFILT; i++) begin
            span[i] = `PFS_FILT_W'(`PFS_SHORT_CYC);
        end
        span[`PFS_P_OT] = `PFS_FILT_W'(OT_DELAY_CYC);
    end

    for (genvar g = 0; g < `PFS_NFILT; g++) begin : g_settle
        pfs_settle #(
            .CW(`PFS_FILT_W)
        ) u_settle (
            .pclk(pclk),
            .presetn(presetn),
            .in_lvl(raw[g]),
            .span(span[g]),
            .out_lvl(settled[g])
        );
    end

    // ------------------------------------------------------------------------
    // Protection state machines
    // ------------------------------------------------------------------------
    // Retry waits the full period and for the condition to clear; an
    // overtemperature trip also waits the full period, then for the die to cool to 110 C.
    always_comb begin
        release_ok[`PFS_P_UV] = !settled[`PFS_P_UV];
        release_ok[`PFS_P_OT] = meas.temp_c <= `PFS_OT_ON_C;
        release_ok[`PFS_P_TRK] = !settled[`PFS_P_TRK];
    end

    always_comb begin
        for (int i = 0; i < `PFS_NPROT; i++) begin
            st_nxt[i] = st_r[i];
            rcnt_nxt[i] = rcnt_r[i];
            case (st_r[i])
                pfs_pkg::PFS_RUN: begin
                    rcnt_nxt[i] = '0;
                    if (settled[i]) begin
                        st_nxt[i] = ctrl_r.latch[i] ? pfs_pkg::PFS_LOCK
                                                    : pfs_pkg::PFS_TRIP;
                    end
                end
                pfs_pkg::PFS_TRIP: begin
                    if (rcnt_r[i] >= `PFS_RETRY_W'(RETRY_CYC - 1)) begin
                        if (release_ok[i]) begin
                            st_nxt[i] = pfs_pkg::PFS_RUN;
                        end
                    end else begin
                        rcnt_nxt[i] = rcnt_r[i] + `PFS_RETRY_W'(1);
                    end
                end
                pfs_pkg::PFS_LOCK: st_nxt[i] = pfs_pkg::PFS_LOCK;
                default: st_nxt[i] = pfs_pkg::PFS_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `PFS_NPROT; i++) begin
                st_r[i] <= pfs_pkg::PFS_RUN;
                rcnt_r[i] <= '0;
            end
        end else begin
            st_r <= st_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs and status
    // ------------------------------------------------------------------------
    always_comb begin
        stat.turn_off = turn_off;
        stat.pg = power_good_out;
        stat.ot_warn = settled[`PFS_F_WARN];
        for (int i = 0; i < `PFS_NPROT; i++) begin
            stat.fault[i] = st_r[i] != pfs_pkg::PFS_RUN;
        end
        turn_off_nxt = |stat.fault;
        pwm_en_nxt = ctrl_r.out_en && !(|stat.fault);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            turn_off <= 1'b0;
            pwm_enable <= 1'b0;
        end else begin
            turn_off <= turn_off_nxt;
            pwm_enable <= pwm_en_nxt;
        end
    end

    assign power_good_out = settled[`PFS_F_PG];

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_UV_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(settled[`PFS_P_UV]) |-> $past(raw[`PFS_P_UV], 1) &&
                                     $past(raw[`PFS_P_UV], `PFS_SHORT_CYC))
        else $error("Undervoltage fault qualified without the full delay.");

    AST_UV_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        (meas.ramp_up || !pwm_enable) |-> !raw[`PFS_P_UV])
        else $error("Undervoltage checked while off or ramping.");

    AST_OT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[`PFS_P_OT] != pfs_pkg::PFS_RUN && meas.temp_c > `PFS_OT_ON_C)
        |=> st_r[`PFS_P_OT] != pfs_pkg::PFS_RUN)
        else $error("Overtemperature released above the restart level.");

    AST_OT_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(settled[`PFS_P_OT]) |-> $past(raw[`PFS_P_OT], 1))
        else $error("Overtemperature qualified without a hot sample.");

    AST_TRK_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(settled[`PFS_P_TRK]) |-> $past(meas.ramp_up, 1) &&
                                      $past(ctrl_r.track_en, `PFS_SHORT_CYC))
        else $error("Tracking fault outside an enabled ramp.");

    AST_WARN_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(stat.ot_warn) |-> $past(warn_lvl_r, `PFS_SHORT_CYC))
        else $error("Warning raised without the full delay.");

    AST_PG_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(power_good_out) |-> $past(raw[`PFS_F_PG], 1) == power_good_out &&
            $past(raw[`PFS_F_PG], `PFS_SHORT_CYC) == power_good_out)
        else $error("Power good changed without a settled window state.");

    // Power good may stay high for the settling delay after leaving the window,
    // so only its rising edge is held against the upper threshold.
    AST_PG_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(power_good_out) |-> !$past(pfs_above(meas.vout_mv, vset_r, `PFS_PG_HI_PCT), 1))
        else $error("Power good rose above the upper window.");

    AST_LOCK_STAYS: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r[`PFS_P_UV] == pfs_pkg::PFS_LOCK) |=> (st_r[`PFS_P_UV] == pfs_pkg::PFS_LOCK)
            ##1 (st_r[`PFS_P_UV] == pfs_pkg::PFS_LOCK))
        else $error("Latched undervoltage fault released.");

    AST_STOP_SWITCH: assert property (@(posedge pclk) disable iff (!presetn)
        (|stat.fault) |=> !pwm_enable && turn_off)
        else $error("Switching continued during a fault.");

endmodule : pfs_supervisor

// >>> dv/pfs_stage_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Power stage and measurement front end
// ---------------------------------------------------------------------------
// The output falls to zero the moment switching stops. A real output capacitor
// would be gentler, but the hard drop exposes any restart that comes too early.
module pfs_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwm_enable,
    input wire logic slow,
    input wire logic [15:0] vout_tgt,
    input wire logic [15:0] ref_tgt,
    input wire logic signed [9:0] temp_tgt,
    input wire logic ramp_tgt,
    output pfs_pkg::pfs_meas_t meas
);
    pfs_pkg::pfs_meas_t meas_r;
    pfs_pkg::pfs_meas_t meas_nxt;
    logic skip_r;
    logic skip_nxt;

    // Next sample. In slow mode the front end refreshes only every other cycle.
    always_comb begin
        meas_nxt = meas_r;
        skip_nxt = slow ? ~skip_r : 1'b0;
        if (!(slow && skip_r)) begin
            meas_nxt.vout_mv = pwm_enable ? vout_tgt : 16'h0000;
            meas_nxt.track_ref_mv = ref_tgt;
            meas_nxt.temp_c = temp_tgt;
            meas_nxt.ramp_up = ramp_tgt;
        end
    end

    // Sample register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_r <= '0;
            skip_r <= 1'b0;
        end else begin
            meas_r <= meas_nxt;
            skip_r <= skip_nxt;
        end
    end

    assign meas = meas_r;

endmodule : pfs_stage_model

// >>> dv/pol_fault_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"

module pol_fault_supervisor_tb_top;
    // -----------------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------------
    localparam int OT_CYC = 50;
    localparam int RETRY = 300;
    localparam int VSET = 2500;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slow = 1'b0;
    logic ramp = 1'b0;
    logic [15:0] vtgt = 16'h09C4;
    logic [15:0] rtgt = 16'h0000;
    logic signed [9:0] temp = 10'sh019;
    pfs_pkg::pfs_meas_t meas;
    logic power_good_out;
    logic turn_off;
    logic pwm_enable;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic er;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    int s;
    int i;
    int lo;
    int vals[8];

    // Clock at 40 MHz.
    always #12.5 pclk = ~pclk;

    pfs_supervisor #(.OT_DELAY_CYC(OT_CYC), .RETRY_CYC(RETRY)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas(meas), .power_good_out(power_good_out),
        .turn_off(turn_off), .pwm_enable(pwm_enable));

    pfs_stage_model i_stage (.pclk(pclk), .presetn(presetn), .pwm_enable(pwm_enable),
        .slow(slow), .vout_tgt(vtgt), .ref_tgt(rtgt), .temp_tgt(temp),
        .ramp_tgt(ramp), .meas(meas));

    // -----------------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk1(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk1

    task automatic chk32(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk32

    task automatic wc(input int k);
        repeat (k) @(posedge pclk);
    endtask : wc

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits a bounded time for the turn-off command to reach a level.
    task automatic wto(input logic want, input int maxc);
        n = 0;
        while (turn_off !== want && n < maxc) begin
            @(posedge pclk);
            n++;
        end
        chk1(want, turn_off);
    endtask : wto

    function automatic logic pg_exp(input int v, input int sel);
        return v >= VSET * (90 + 5 * sel) / 100 && v <= VSET * 110 / 100;
    endfunction : pg_exp

    // Hang guard: the tests need well under 30000 cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 60000) begin
            err_total++;
            finish_test();
        end
    end

    // -----------------------------------------------------------------------
    // Tests
    // -----------------------------------------------------------------------
    initial begin
        rnd = $urandom(38801);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wc(300);
        apb(1'b0, `PFS_OFF_CTRL, 32'h0); chk32(32'h00000001, rd);
        apb(1'b0, `PFS_OFF_THR, 32'h0); chk32(32'h00000000, rd);
        chk1(1'b0, er);
        apb(1'b0, `PFS_OFF_VSET, 32'h0); chk32(32'h000009C4, rd);
        rnd = $urandom;
        apb(1'b1, `PFS_OFF_VSET, rnd);
        apb(1'b0, `PFS_OFF_VSET, 32'h0); chk32({16'h0000, rnd[15:0]}, rd);
        apb(1'b1, `PFS_OFF_VSET, 32'h000009C4);
        apb(1'b1, `PFS_OFF_STAT, 32'hFFFFFFFF);
        apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'h00000010, rd);
        apb(1'b0, 8'h10, 32'h0); chk32(32'h0, rd);
        chk1(1'b1, er);
        $display("test registers done");
        // Window edges for both lower settings, then random levels.
        for (s = 0; s < 2; s++) begin
            slow <= s[0];
            apb(1'b1, `PFS_OFF_THR, 32'(s) << 2);
            lo = VSET * (90 + 5 * s) / 100;
            vals = '{lo - 1, lo, 2751, 2750, 0, 0, 0, 0};
            for (i = 4; i < 8; i++) vals[i] = 1900 + $urandom % 1300;
            vtgt <= 16'h09C4;
            wc(260);
            for (i = 0; i < 8; i++) begin
                vtgt <= vals[i][15:0];
                wc(230);
                if (i == 0) chk1(1'b1, power_good_out);
                wc(25);
                chk1(pg_exp(vals[i], s), power_good_out);
            end
        end
        slow <= 1'b0;
        vtgt <= 16'h09C4;
        wc(260);
        $display("test power good done");
        // Every undervoltage step: at the threshold, then one millivolt below.
        for (s = 0; s < 4; s++) begin
            apb(1'b1, `PFS_OFF_THR, 32'(s));
            lo = VSET * (75 + 5 * s) / 100;
            vtgt <= 16'(lo);
            wc(300); chk1(1'b0, turn_off);
            vtgt <= 16'(lo - 1);
            wc(235); chk1(1'b0, turn_off);
            wto(1'b1, 30);
            chk1(1'b0, pwm_enable);
            apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'h21, rd & 32'h21);
            vtgt <= 16'h09C4;
            wto(1'b0, RETRY + 300);
            chk1(1'b1, n > RETRY - 30);
        end
        apb(1'b1, `PFS_OFF_CTRL, 32'h00000005);
        vtgt <= 16'h0708;
        wto(1'b1, 300);
        vtgt <= 16'h09C4;
        wc(RETRY + 400); chk1(1'b1, turn_off);
        presetn <= 1'b0;
        wc(3);
        presetn <= 1'b1;
        wc(2); chk1(1'b0, turn_off);
        apb(1'b0, `PFS_OFF_CTRL, 32'h0); chk32(32'h00000001, rd);
        wc(300);
        $display("test undervoltage done");
        // Temperature: below the limit, trip, warning hysteresis, restart point.
        temp <= 10'sh077;
        wc(400); chk1(1'b0, turn_off);
        apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'h0, rd & 32'h8);
        temp <= 10'sh078;
        wto(1'b1, OT_CYC + 20);
        chk1(1'b1, n > OT_CYC - 5);
        wc(170);
        apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'h2, rd & 32'hA);
        wc(30);
        apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'hA, rd & 32'hA);
        temp <= 10'sh076;
        wc(300);
        apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'h8, rd & 32'h8);
        temp <= 10'sh075;
        wc(300);
        apb(1'b0, `PFS_OFF_STAT, 32'h0); chk32(32'h0, rd & 32'h8);
        temp <= 10'sh06F;
        wc(300); chk1(1'b1, turn_off);
        temp <= 10'sh06E;
        wto(1'b0, 20);
        temp <= 10'sh019;
        wc(300);
        $display("test temperature done");
        // Tracking: off after reset, boundary error, both signs, ramp only.
        ramp <= 1'b1;
        rtgt <= 16'h09C4;
        vtgt <= 16'h0AF0;
        wc(400); chk1(1'b0, turn_off);
        vtgt <= 16'h0ABE;
        wc(5);
        apb(1'b1, `PFS_OFF_CTRL, 32'h00000003);
        wc(400); chk1(1'b0, turn_off);
        vtgt <= 16'h08C9;
        wc(235); chk1(1'b0, turn_off);
        wto(1'b1, 30);
        ramp <= 1'b0;
        wto(1'b0, RETRY + 300);
        ramp <= 1'b1;
        vtgt <= 16'h0ABF;
        wto(1'b1, 280);
        ramp <= 1'b0;
        vtgt <= 16'h09C4;
        wto(1'b0, RETRY + 300);
        $display("test tracking done");
        // Latching overtemperature: cooling must not restart the stage.
        apb(1'b1, `PFS_OFF_CTRL, 32'h00000019);
        temp <= 10'sh078;
        wto(1'b1, OT_CYC + 20);
        temp <= 10'sh019;
        wc(RETRY + 100);
        chk1(1'b1, turn_off);
        apb(1'b0, `PFS_OFF_STAT, 32'h0);
        chk32(32'h22, rd & 32'h27);
        $display("test latching done");
        finish_test();
    end

endmodule : pol_fault_supervisor_tb_top
